// [design/clock_ctrl_params.svh]
// constants of the clock, watchdog and reset control block
`ifndef CLOCK_CTRL_PARAMS_SVH
`define CLOCK_CTRL_PARAMS_SVH
`define CM_PIN_RESET_BIT 0
`define CM_LOW_RC_EN_BIT 2
`define CM_RESET_VALUE 8'h04
`define CM_FAST_HIGH_RC 8'h36
`define XO_ENABLE_BIT 7
`define XO_RANGE_HI 6
`define XO_RANGE_LO 5
`define AUX_WD_HI 1
`define AUX_WD_LO 0
`define AUX_UV_OFF_BIT 2
`define WD_8K 20'h01fff
`define WD_16K 20'h03fff
`define WD_64K 20'h0ffff
`define WD_256K 20'h3ffff
`define FAST_WAKE_PERIODS 6'h2d
`define LOW_RC_DIV 8'hff
`endif

// [design/clock_ctrl_pkg.sv]
// types of the clock, watchdog and reset control block
package clock_ctrl_pkg;
  typedef enum logic [1:0] {
    wake_idle = 2'b00,
    wake_count = 2'b01,
    wake_done = 2'b10
  } wake_state_t;
  typedef enum logic [1:0] {
    xo_off = 2'b00,
    xo_low = 2'b01,
    xo_mid = 2'b10,
    xo_high = 2'b11
  } xo_range_t;
endpackage : clock_ctrl_pkg

// [design/low_rc_divider.sv]
// divider giving one-cycle low-speed rc ticks
`timescale 1ns/1ns
`include "clock_ctrl_params.svh"
module low_rc_divider (
  input wire logic clock,
  input wire logic reset,
  input wire logic enable,
  output logic tick
);
  typedef struct packed {
    logic [7:0] count;
    logic tick;
  } div_state_t;
  div_state_t state;
  div_state_t next_state;
  // count only while the oscillator runs
  always_comb begin
    next_state = state;
    next_state.tick = 1'b0;
    if (enable) begin
      if (state.count == `LOW_RC_DIV) begin
        next_state.count = 8'h00;
        next_state.tick = 1'b1;
      end else begin
        next_state.count = state.count + 8'h01;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  assign tick = state.tick;
endmodule : low_rc_divider

// [design/watchdog_counter.sv]
// watchdog counter on low-speed rc ticks
`timescale 1ns/1ns
`include "clock_ctrl_params.svh"
module watchdog_counter (
  input wire logic clock,
  input wire logic reset,
  input wire logic tick,
  input wire logic enable,
  input wire logic clear,
  input wire logic [1:0] timeout_sel,
  output logic overflow
);
  typedef struct packed {
    logic [19:0] count;
    logic overflow;
  } wd_state_t;
  wd_state_t state;
  wd_state_t next_state;
  // timeout limit decode
  function automatic logic [19:0] limit_of(input logic [1:0] sel);
    case (sel)
      2'b00: limit_of = `WD_8K;
      2'b01: limit_of = `WD_16K;
      2'b10: limit_of = `WD_64K;
      default: limit_of = `WD_256K;
    endcase
  endfunction : limit_of
  // count ticks, pulse overflow at limit
  always_comb begin
    next_state = state;
    next_state.overflow = 1'b0;
    if (clear || !enable) begin
      next_state.count = 20'h00000;
    end else if (tick) begin
      if (state.count >= limit_of(timeout_sel)) begin
        next_state.count = 20'h00000;
        next_state.overflow = 1'b1;
      end else begin
        next_state.count = state.count + 20'h00001;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  assign overflow = state.overflow;
  a_wd_no_tick_hold: assert property (@(posedge clock) disable iff (reset)
    !tick && enable && !clear |=> state.count == $past(state.count)) // RULE_11
    else $error("watchdog moved without a tick");
  a_wd_off_clear: assert property (@(posedge clock) disable iff (reset) // RULE_11
    !enable |=> state.count == 20'h00000)
    else $error("watchdog counted while stopped");
  a_wd_limit_hit: assert property (@(posedge clock) disable iff (reset) // RULE_12
    tick && enable && !clear && state.count == limit_of(timeout_sel) |=> overflow)
    else $error("watchdog limit passed without overflow");
endmodule : watchdog_counter

// [design/clock_watchdog_reset_control.sv]
// clock selection, watchdog, undervoltage and pin reset control
`timescale 1ns/1ns
`include "clock_ctrl_params.svh"
// Function
// RULE_01: shared pin resets chip only when input and mode bit 0 set
// RULE_02: shared pin output is open-drain, never driven high
// RULE_03: crystal control bits 6:5 pick low, middle or high drive range
// RULE_04: crystal control bit 7 enables the crystal oscillator
// RULE_05: software readies crystal pins as inputs, no pull-ups, analog
// RULE_06: software confirms crystal stable before selecting it
// RULE_07: switch source first, disable old oscillator in later write
// RULE_08: mode value 0x36 selects high-speed rc over two, low rc kept
// RULE_09: clearing mode bit 2 stops low rc, only when not system clock
// RULE_10: watchdog enabled after reset; trim routine turns it off
// RULE_11: watchdog stops while low-speed rc is disabled
// RULE_12: aux bits 1:0 choose 8k, 16k, 64k or 256k rc periods
// RULE_13: watchdog overflow resets the chip
// RULE_14: fast wake-up resumes after 45 low-speed rc periods
// RULE_15: undervoltage threshold acts only after power-on completes
// RULE_16: aux bit 2 set disables undervoltage reset
// RULE_17: undervoltage reset idle in idle-halt and deep power-down
module clock_watchdog_reset_control
  import clock_ctrl_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic mode_write,
  input wire logic [7:0] mode_wdata,
  input wire logic xo_write,
  input wire logic [7:0] xo_wdata,
  input wire logic aux_write,
  input wire logic [7:0] aux_wdata,
  input wire logic watchdog_enable_write,
  input wire logic watchdog_enable_value,
  input wire logic watchdog_clear,
  input wire logic pin_is_input,
  input wire logic pin_out_value,
  input wire logic shared_reset_pin_in,
  input wire logic power_on_done,
  input wire logic undervoltage_detect,
  input wire logic idle_halt,
  input wire logic deep_power_down,
  input wire logic fast_wake_sel,
  input wire logic wake_event,
  output logic [7:0] clock_mode_register,
  output logic [7:0] crystal_osc_control,
  output logic [2:0] aux_control,
  output logic crystal_enable,
  output logic [1:0] crystal_range,
  output logic low_rc_enable,
  output logic high_rc_half_sel,
  output logic watchdog_enabled,
  output logic shared_reset_pin_out,
  output logic shared_reset_pin_oe,
  output logic chip_reset,
  output logic switch_fault,
  output logic wake_resume
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] xo;
    logic [2:0] aux;
    logic wd_en;
    logic chip_reset;
    logic fault;
    wake_state_t wake;
    logic [5:0] wake_count;
    logic resume;
  } ctrl_state_t;
  ctrl_state_t state;
  ctrl_state_t next_state;
  logic rc_tick;
  logic wd_overflow;
  logic pin_reset;
  logic uv_reset;
  logic low_rc_needed;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // low rc must stay on while it clocks the system
  function automatic logic low_rc_is_sysclk(input logic [7:0] m);
    low_rc_is_sysclk = (m != `CM_FAST_HIGH_RC) && !(m[7:5] == 3'b001);
  endfunction : low_rc_is_sysclk
  // pin reset gate and undervoltage qualification
  assign pin_reset = pin_is_input && state.mode[`CM_PIN_RESET_BIT] && !shared_reset_pin_in; // RULE_01
  assign uv_reset = power_on_done && undervoltage_detect && !state.aux[`AUX_UV_OFF_BIT] // RULE_15 RULE_16
    && !idle_halt && !deep_power_down; // RULE_17
  assign low_rc_needed = low_rc_is_sysclk(state.mode);
  // ---------------------------------------------------------------
  // sub blocks
  // ---------------------------------------------------------------
  // low rc tick source, stopped with the oscillator
  low_rc_divider u_div (
    .clock(clock),
    .reset(reset),
    .enable(state.mode[`CM_LOW_RC_EN_BIT]),
    .tick(rc_tick)
  );
  // watchdog runs only while low rc runs
  watchdog_counter u_wd (
    .clock(clock),
    .reset(reset || state.chip_reset),
    .tick(rc_tick),
    .enable(state.wd_en && state.mode[`CM_LOW_RC_EN_BIT]), // RULE_11
    .clear(watchdog_clear),
    .timeout_sel(state.aux[`AUX_WD_HI:`AUX_WD_LO]), // RULE_12
    .overflow(wd_overflow)
  );
  // ---------------------------------------------------------------
  // control update
  // ---------------------------------------------------------------
  // next state from writes, reset causes and wake-up count
  always_comb begin
    next_state = state;
    next_state.chip_reset = wd_overflow || pin_reset || uv_reset; // RULE_13
    next_state.resume = 1'b0;
    if (mode_write) begin
      // refuse killing low rc in the same write that leaves it
      if (!mode_wdata[`CM_LOW_RC_EN_BIT] && (low_rc_needed || low_rc_is_sysclk(mode_wdata))) begin // RULE_07 RULE_09
        next_state.mode = {mode_wdata[7:3], 1'b1, mode_wdata[1:0]};
        next_state.fault = 1'b1;
      end else begin
        next_state.mode = mode_wdata; // RULE_08
      end
    end
    if (xo_write) begin
      next_state.xo = xo_wdata; // RULE_03 RULE_04
    end
    if (aux_write) begin
      next_state.aux = aux_wdata[2:0];
    end
    if (watchdog_enable_write) begin
      next_state.wd_en = watchdog_enable_value; // RULE_10
    end
    // fast wake-up count in low rc periods
    case (state.wake)
      wake_idle: begin
        if (wake_event && fast_wake_sel) begin
          next_state.wake = wake_count;
          next_state.wake_count = 6'h00;
        end
      end
      wake_count: begin
        if (rc_tick) begin
          if (state.wake_count == `FAST_WAKE_PERIODS - 6'h01) begin // RULE_14
            next_state.wake = wake_done;
          end else begin
            next_state.wake_count = state.wake_count + 6'h01;
          end
        end
      end
      wake_done: begin
        next_state.resume = 1'b1;
        next_state.wake = wake_idle;
      end
      default: next_state.wake = wake_idle;
    endcase
  end
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // reset and chip reset load the same defaults
  always_ff @(posedge clock) begin
    if (reset || state.chip_reset) begin
      state <= '0;
      state.mode <= `CM_RESET_VALUE;
      state.wd_en <= 1'b1; // RULE_10
      state.wake <= wake_idle;
    end else begin
      state <= next_state;
    end
  end
  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // registered values and levels derived from them; shared pin drive from pin_is_input and pin_out_value
  assign clock_mode_register = state.mode;
  assign crystal_osc_control = state.xo;
  assign aux_control = state.aux;
  assign crystal_enable = state.xo[`XO_ENABLE_BIT]; // RULE_04
  assign crystal_range = state.xo[`XO_RANGE_HI:`XO_RANGE_LO]; // RULE_03
  assign low_rc_enable = state.mode[`CM_LOW_RC_EN_BIT]; // RULE_09
  assign high_rc_half_sel = (state.mode == `CM_FAST_HIGH_RC); // RULE_08
  assign watchdog_enabled = state.wd_en;
  assign shared_reset_pin_out = 1'b0; // RULE_02
  assign shared_reset_pin_oe = !pin_is_input && !pin_out_value; // RULE_02
  assign chip_reset = state.chip_reset;
  assign switch_fault = state.fault;
  assign wake_resume = state.resume;
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // pin reset taken one cycle after the gated low level
  a_pin_reset_gate: assert property (@(posedge clock) disable iff (reset) // RULE_01
    pin_reset && !state.chip_reset |=> chip_reset)
    else $error("pin reset not taken");
  // pin ignored unless input and mode bit set
  a_pin_gate_off: assert property (@(posedge clock) disable iff (reset) // RULE_01
    (!pin_is_input || !clock_mode_register[`CM_PIN_RESET_BIT]) && !wd_overflow && !uv_reset |=> !chip_reset)
    else $error("pin reset taken while gated off");
  // open drain only ever pulls low
  a_pin_never_high: assert property (@(posedge clock) disable iff (reset) // RULE_02
    shared_reset_pin_oe |-> !shared_reset_pin_out)
    else $error("shared pin driven high");
  // input mode leaves the pin released
  a_pin_input_free: assert property (@(posedge clock) disable iff (reset) // RULE_02
    pin_is_input |-> !shared_reset_pin_oe)
    else $error("shared pin driven in input mode");
  // output low pulls the pin down
  a_pin_output_low: assert property (@(posedge clock) disable iff (reset) // RULE_02
    !pin_is_input && !pin_out_value |-> shared_reset_pin_oe)
    else $error("shared pin not pulled low");
  // crystal enable and range follow a write
  a_xo_enable_bit: assert property (@(posedge clock) disable iff (reset || chip_reset) // RULE_04
    xo_write |=> crystal_enable == $past(xo_wdata[7]) && crystal_range == $past(xo_wdata[6:5]))
    else $error("crystal control not stored");
  // whole crystal control word stored
  a_xo_word_stored: assert property (@(posedge clock) disable iff (reset) // RULE_03
    xo_write && !chip_reset |=> crystal_osc_control == $past(xo_wdata))
    else $error("crystal control word lost");
  // drive range kept between writes
  a_xo_range_hold: assert property (@(posedge clock) disable iff (reset) // RULE_03
    !xo_write && !chip_reset |=> $stable(crystal_range))
    else $error("crystal range changed without a write");
  // chip reset stops the crystal
  a_xo_reset_off: assert property (@(posedge clock) disable iff (reset) // RULE_04
    chip_reset |=> !crystal_enable && crystal_range == 2'b00)
    else $error("crystal left on after chip reset");
  // fast rc mode chosen by its mode value
  a_mode_fast_rc: assert property (@(posedge clock) disable iff (reset || chip_reset) // RULE_08
    mode_write && mode_wdata == `CM_FAST_HIGH_RC |=> high_rc_half_sel && low_rc_enable)
    else $error("fast rc mode not selected");
  // mode kept between writes
  a_mode_hold: assert property (@(posedge clock) disable iff (reset) // RULE_08
    !mode_write && !chip_reset |=> $stable(clock_mode_register))
    else $error("clock mode changed without a write");
  // low rc stays on while it clocks the system
  a_low_rc_kept: assert property (@(posedge clock) disable iff (reset) // RULE_09
    low_rc_needed && !chip_reset |=> low_rc_enable)
    else $error("low rc stopped while clocking");
  // legal mode writes land unchanged
  a_switch_allowed: assert property (@(posedge clock) disable iff (reset) // RULE_09
    mode_write && (mode_wdata[`CM_LOW_RC_EN_BIT] || (!low_rc_needed && !low_rc_is_sysclk(mode_wdata)))
    && !chip_reset |=> clock_mode_register == $past(mode_wdata))
    else $error("legal mode write not stored");
  // switch and shutdown in one write refused
  a_switch_refused: assert property (@(posedge clock) disable iff (reset) // RULE_07
    mode_write && !mode_wdata[`CM_LOW_RC_EN_BIT] && low_rc_needed && !chip_reset |=> low_rc_enable && switch_fault)
    else $error("unsafe clock switch not refused");
  // fault flag held until chip reset
  a_fault_sticky: assert property (@(posedge clock) disable iff (reset) // RULE_07
    switch_fault && !chip_reset |=> switch_fault)
    else $error("switch fault lost");
  // watchdog on after reset
  a_wd_after_reset: assert property (@(posedge clock) // RULE_10
    reset |=> watchdog_enabled)
    else $error("watchdog off after reset");
  // chip reset re-enables the watchdog
  a_wd_reset_on: assert property (@(posedge clock) disable iff (reset) // RULE_10
    chip_reset |=> watchdog_enabled)
    else $error("watchdog off after chip reset");
  // trim routine can turn the watchdog off
  a_wd_trim_off: assert property (@(posedge clock) disable iff (reset) // RULE_10
    watchdog_enable_write && !watchdog_enable_value && !chip_reset |=> !watchdog_enabled)
    else $error("watchdog not turned off");
  // no overflow while low rc is off
  a_wd_gated: assert property (@(posedge clock) disable iff (reset) // RULE_11
    !low_rc_enable |=> !wd_overflow)
    else $error("watchdog overflow without low rc");
  // overflow resets the chip
  a_wd_overflow_rst: assert property (@(posedge clock) disable iff (reset) // RULE_13
    wd_overflow && !chip_reset |=> chip_reset)
    else $error("overflow did not reset");
  // no undervoltage reset before power-on completes
  a_uv_before_power: assert property (@(posedge clock) disable iff (reset) // RULE_15
    !power_on_done && !wd_overflow && !pin_reset |=> !chip_reset)
    else $error("undervoltage reset before power-on");
  // qualified undervoltage resets the chip
  a_uv_taken: assert property (@(posedge clock) disable iff (reset) // RULE_15
    uv_reset && !chip_reset |=> chip_reset)
    else $error("undervoltage reset not taken");
  // aux word stored
  a_aux_stored: assert property (@(posedge clock) disable iff (reset) // RULE_16
    aux_write && !chip_reset |=> aux_control == $past(aux_wdata[2:0]))
    else $error("aux control not stored");
  // undervoltage off by aux bit
  a_uv_disabled: assert property (@(posedge clock) disable iff (reset) // RULE_16
    aux_control[`AUX_UV_OFF_BIT] && !wd_overflow && !pin_reset |=> !chip_reset)
    else $error("undervoltage reset while disabled");
  // undervoltage idle in stop modes
  a_uv_stop_modes: assert property (@(posedge clock) disable iff (reset) // RULE_17
    (idle_halt || deep_power_down) && !wd_overflow && !pin_reset |=> !chip_reset)
    else $error("undervoltage reset in stop mode");
  // resume two cycles after the last tick
  a_wake_last_tick: assert property (@(posedge clock) disable iff (reset || chip_reset) // RULE_14
    state.wake == wake_count && rc_tick && state.wake_count == `FAST_WAKE_PERIODS - 6'h01 |=> ##1 wake_resume)
    else $error("wake-up resume missing");
  // no resume before the last tick
  a_wake_no_early: assert property (@(posedge clock) disable iff (reset) // RULE_14
    state.wake == wake_count && !(rc_tick && state.wake_count == `FAST_WAKE_PERIODS - 6'h01)
    |=> !wake_resume && state.wake != wake_done)
    else $error("wake-up resume too early");
  // resume is a single cycle pulse
  a_resume_pulse: assert property (@(posedge clock) disable iff (reset) // RULE_14
    wake_resume |=> !wake_resume)
    else $error("wake-up resume held");
endmodule : clock_watchdog_reset_control

// [tb/clock_watchdog_reset_control_tb.sv]
// self-checking testbench of the clock, watchdog and reset control block
`timescale 1ns/1ns
module clock_watchdog_reset_control_tb;
  import clock_ctrl_pkg::*;
  logic clock, reset, mode_write, xo_write, aux_write, watchdog_enable_write, watchdog_enable_value;
  logic [7:0] mode_wdata, xo_wdata, aux_wdata;
  logic pin_is_input, pin_out_value, pin_ext, power_on_done, undervoltage_detect, idle_halt;
  logic deep_power_down, fast_wake_sel, wake_event, watchdog_clear;
  logic [7:0] clock_mode_register, crystal_osc_control;
  logic [2:0] aux_control;
  logic [1:0] crystal_range;
  logic crystal_enable, low_rc_enable, high_rc_half_sel, watchdog_enabled, shared_reset_pin_out;
  logic shared_reset_pin_oe, chip_reset, switch_fault, wake_resume;
  wire shared_reset_pin_in;
  int fail_count;
  int n_tests;

  // ---------------------------------------------
  // open-drain wire, released level set by pin_ext
  // ---------------------------------------------
  assign shared_reset_pin_in = shared_reset_pin_oe ? shared_reset_pin_out : pin_ext;

  clock_watchdog_reset_control DUT (.clock(clock), .reset(reset), .mode_write(mode_write),
    .mode_wdata(mode_wdata), .xo_write(xo_write), .xo_wdata(xo_wdata), .aux_write(aux_write),
    .aux_wdata(aux_wdata), .watchdog_enable_write(watchdog_enable_write),
    .watchdog_enable_value(watchdog_enable_value), .watchdog_clear(watchdog_clear), .pin_is_input(pin_is_input),
    .pin_out_value(pin_out_value), .shared_reset_pin_in(shared_reset_pin_in), .power_on_done(power_on_done),
    .undervoltage_detect(undervoltage_detect), .idle_halt(idle_halt), .deep_power_down(deep_power_down),
    .fast_wake_sel(fast_wake_sel), .wake_event(wake_event), .clock_mode_register(clock_mode_register),
    .crystal_osc_control(crystal_osc_control), .aux_control(aux_control), .crystal_enable(crystal_enable),
    .crystal_range(crystal_range), .low_rc_enable(low_rc_enable), .high_rc_half_sel(high_rc_half_sel),
    .watchdog_enabled(watchdog_enabled), .shared_reset_pin_out(shared_reset_pin_out),
    .shared_reset_pin_oe(shared_reset_pin_oe), .chip_reset(chip_reset), .switch_fault(switch_fault),
    .wake_resume(wake_resume));

  // ---------------------------------------------
  // shared tasks
  // ---------------------------------------------
  // clock generator
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  task check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task wr_mode(input logic [7:0] d);
    mode_wdata = d;
    mode_write = 1'b1;
    step(1);
    mode_write = 1'b0;
    step(1);
  endtask : wr_mode

  task wr_xo(input logic [7:0] d);
    xo_wdata = d;
    xo_write = 1'b1;
    step(1);
    xo_write = 1'b0;
    step(1);
  endtask : wr_xo

  task wr_aux(input logic [7:0] d);
    aux_wdata = d;
    aux_write = 1'b1;
    step(1);
    aux_write = 1'b0;
    step(1);
  endtask : wr_aux

  // looks for a chip reset pulse over four cycles
  task expect_reset(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (4) begin
      if (chip_reset === 1'b1) seen = 1'b1;
      step(1);
    end
    check({7'h00, seen}, {7'h00, exp});
  endtask : expect_reset

  task do_reset();
    pin_is_input = 1'b1;
    pin_ext = 1'b1;
    undervoltage_detect = 1'b0;
    reset = 1'b1;
    step(2);
    reset = 1'b0;
    step(1);
  endtask : do_reset

  task print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task t_reset_values();
    do_reset();
    check(clock_mode_register, 8'h04);
    check({7'h00, watchdog_enabled}, 8'h01);
    watchdog_enable_value = 1'b0;
    watchdog_enable_write = 1'b1;
    step(1);
    watchdog_enable_write = 1'b0;
    step(1);
    check({7'h00, watchdog_enabled}, 8'h00);
    $display("reset values done");
  endtask : t_reset_values

  task t_crystal();
    for (int r = 1; r < 4; r++) begin
      wr_xo({1'b1, r[1:0], 5'h00});
      check(crystal_osc_control, {1'b1, r[1:0], 5'h00});
      check({6'h00, crystal_range}, r[7:0]);
      check({7'h00, crystal_enable}, 8'h01);
    end
    wr_xo(8'h20);
    check({7'h00, crystal_enable}, 8'h00);
    $display("crystal control done");
  endtask : t_crystal

  task t_switch();
    do_reset();
    wr_mode(8'h36);
    check({7'h00, high_rc_half_sel}, 8'h01);
    check({7'h00, low_rc_enable}, 8'h01);
    wr_mode(8'h32);
    check({7'h00, low_rc_enable}, 8'h00);
    check({7'h00, switch_fault}, 8'h00);
    do_reset();
    wr_mode(8'h50);
    check(clock_mode_register, 8'h54);
    check({7'h00, low_rc_enable}, 8'h01);
    check({7'h00, switch_fault}, 8'h01);
    $display("clock switching done");
  endtask : t_switch

  task t_pin();
    do_reset();
    pin_ext = 1'b0;
    expect_reset(1'b0);
    pin_ext = 1'b1;
    wr_mode(8'h05);
    pin_ext = 1'b0;
    expect_reset(1'b1);
    pin_ext = 1'b1;
    wr_mode(8'h05);
    pin_is_input = 1'b0;
    pin_out_value = 1'b0;
    step(2);
    check({6'h00, shared_reset_pin_oe, shared_reset_pin_out}, 8'h02);
    expect_reset(1'b0);
    pin_out_value = 1'b1;
    step(2);
    check({6'h00, shared_reset_pin_oe, shared_reset_pin_out}, 8'h00);
    $display("shared pin done");
  endtask : t_pin

  task t_undervoltage();
    do_reset();
    power_on_done = 1'b0;
    undervoltage_detect = 1'b1;
    expect_reset(1'b0);
    power_on_done = 1'b1;
    idle_halt = 1'b1;
    expect_reset(1'b0);
    idle_halt = 1'b0;
    deep_power_down = 1'b1;
    expect_reset(1'b0);
    deep_power_down = 1'b0;
    undervoltage_detect = 1'b0;
    wr_aux(8'h04);
    check({5'h00, aux_control}, 8'h04);
    undervoltage_detect = 1'b1;
    expect_reset(1'b0);
    undervoltage_detect = 1'b0;
    wr_aux(8'h00);
    undervoltage_detect = 1'b1;
    expect_reset(1'b1);
    undervoltage_detect = 1'b0;
    $display("undervoltage done");
  endtask : t_undervoltage

  task t_wake();
    int c;
    do_reset();
    fast_wake_sel = 1'b1;
    wake_event = 1'b1;
    step(1);
    wake_event = 1'b0;
    c = 0;
    while (wake_resume !== 1'b1 && c < 12000) begin
      step(1);
      c++;
    end
    // first low rc tick lands anywhere in one 256-clock period
    check({7'h00, c >= 44 * 256 && c <= 45 * 256 + 3}, 8'h01);
    $display("fast wake-up done after %0d cycles", c);
  endtask : t_wake

  // watchdog counts, restarts and stops with low rc
  task t_watchdog();
    do_reset();
    step(600);
    check({7'h00, DUT.u_wd.state.count != 20'h00000}, 8'h01);
    watchdog_clear = 1'b1;
    step(1);
    watchdog_clear = 1'b0;
    check({7'h00, DUT.u_wd.state.count == 20'h00000}, 8'h01);
    wr_mode(8'h36);
    wr_mode(8'h32);
    step(600);
    check({7'h00, DUT.u_wd.state.count == 20'h00000}, 8'h01);
    check({7'h00, watchdog_enabled}, 8'h01);
    expect_reset(1'b0);
    $display("watchdog done");
  endtask : t_watchdog

  // ---------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------
  initial begin
    fail_count = 0;
    n_tests = 0;
    {mode_write, xo_write, aux_write, watchdog_enable_write, watchdog_enable_value} = 5'h00;
    {mode_wdata, xo_wdata, aux_wdata} = 24'h000000;
    {pin_is_input, pin_out_value, pin_ext, power_on_done} = 4'h0;
    {undervoltage_detect, idle_halt, deep_power_down, fast_wake_sel, wake_event} = 5'h00;
    watchdog_clear = 1'b0;
    reset = 1'b1;
    step(20);
    reset = 1'b0;
    step(1);
    t_reset_values();
    t_crystal();
    t_switch();
    t_pin();
    t_undervoltage();
    t_wake();
    t_watchdog();
    print_verdict();
  end

  // cuts a hang short well beyond the expected run
  initial begin
    #3000000;
    fail_count++;
    print_verdict();
  end
endmodule : clock_watchdog_reset_control_tb
